/* File: rtl/uart_rx_pkg.sv */
// Constants and carriers shared by the serial receive status and bit-rate block.
// Assumes one 100 MHz clock and an AHB-Lite master with 32-bit data.
package uart_rx_pkg;
    // ----------------------------------------
    // Register indices (byte address = 4 x index)
    // ----------------------------------------
    localparam logic [15:0] IDX_MODE = 16'hff90;
    localparam logic [15:0] IDX_BRGC = 16'hff91;
    localparam logic [15:0] IDX_RXBUF = 16'hff92;
    localparam logic [15:0] IDX_ERRSTAT = 16'hff93;
    localparam logic [15:0] IDX_IRQSTAT = 16'hff94;
    localparam logic [15:0] IDX_IRQMASK = 16'hff95;
    // ----------------------------------------
    // Reset values and fields
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] BRGC_RESET = 8'h1f;
    localparam logic [7:0] ERRSTAT_RESET = 8'h00;
    localparam int BRGC_ZERO_BIT = 5;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int REF_CLK_HZ = 100000000;
    localparam int SUB_CLK_HZ = 32768;
    // One period of four times the subsystem clock, rounded down
    localparam int QUAD_CYCLES = REF_CLK_HZ / (4 * SUB_CLK_HZ);
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic power;
        logic tx_enable;
        logic rx_enable;
        logic [1:0] parity_mode;
        logic char_len8;
        logic stop_length_select;
        logic error_interrupt_mode;
    } mode_type;
    typedef struct packed {
        logic [1:0] clock_select;
        logic zero;
        logic [4:0] divide_value;
    } brgc_type;
    typedef struct packed {
        logic [4:0] zero;
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
    } errstat_type;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP = 3'b100
    } rx_state_type;
endpackage

/* File: rtl/uart_rx_status.sv */
// Receive error status, receiver and bit-rate generator of an async serial port.
// Assumes RXD synchronous to REF_CLK and a single AHB-Lite master.
// What this block does
// - Error status is 8-bit read-only, reset zero.
// - System reset clears every error status bit.
// - Missing stop bit sets framing error flag.
// - Receiver checks only one stop bit.
// - Frame done with unread buffer sets overrun.
// - Overrun repeats each frame until buffer read.
// - On overrun new byte dropped, buffer kept.
// - Bit-rate control 8-bit read/write, reset 1f.
// - Bits 7:6 select divider input clock.
// - Bits 4:0 give divide value k, 8..31.
// - Bit rate is input clock over 2k.
// - Even/odd parity check includes the parity bit.
// - Enable bit low holds internal circuit reset.
// - Error mode bit steers error to one interrupt.
module uart_rx_status #(
    parameter int QUAD_CYC = uart_rx_pkg::QUAD_CYCLES
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Serial line
    input wire logic RXD,
    // Interrupt
    output logic IRQ
);
    import uart_rx_pkg::*;

    mode_type mode, next_mode;
    brgc_type brgc, next_brgc;
    logic [1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
    logic [31:0] next_hrdata;
    logic wr_pend, next_wr_pend;
    logic [15:0] wr_idx, next_wr_idx;
    logic read_buf;
    logic [11:0] pre_cnt, next_pre_cnt;
    logic [3:0] sel_cnt, next_sel_cnt;
    logic [4:0] k_cnt, next_k_cnt;
    logic half_tick;
    rx_state_type rx_state, next_rx_state;
    logic phase, next_phase;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift, rx_buf, next_rx_buf;
    logic par_acc, next_par_acc, par_err, next_par_err;
    logic buf_full, next_buf_full;
    errstat_type err_stat, next_err_stat;
    logic frame_done, ev_done, ev_err, start_det, ove_now, stop_low;

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    // Zero wait states: the master never overlaps a write data phase with
    // the next address phase, so a read never sees a stale register.
    logic addr_ok;
    logic [15:0] a_idx;
    assign a_idx = HADDR[17:2];
    assign addr_ok = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HADDR[31:18] == 14'h0;
    assign read_buf = addr_ok && !HWRITE && a_idx == IDX_RXBUF;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign IRQ = |(irq_stat & irq_mask);

    always_comb begin
        next_mode = mode;
        next_brgc = brgc;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_hrdata = HRDATA;
        next_wr_pend = addr_ok && HWRITE;
        next_wr_idx = a_idx;
        if (wr_pend) begin
            case (wr_idx)
                IDX_MODE: next_mode = mode_type'(HWDATA[7:0]);
                IDX_BRGC: begin
                    next_brgc = brgc_type'(HWDATA[7:0]);
                    next_brgc.zero = 1'b0;
                end
                IDX_IRQSTAT: next_irq_stat = irq_stat & ~HWDATA[1:0];
                IDX_IRQMASK: next_irq_mask = HWDATA[1:0];
                default: ;
            endcase
        end
        // Hardware set wins over a same-cycle write-one clear
        if (ev_done) next_irq_stat[IRQ_DONE_BIT] = 1'b1;
        if (ev_err) next_irq_stat[IRQ_ERR_BIT] = 1'b1;
        if (addr_ok && !HWRITE) begin
            case (a_idx)
                IDX_MODE: next_hrdata = {24'h0, mode};
                IDX_BRGC: next_hrdata = {24'h0, brgc};
                IDX_RXBUF: next_hrdata = {24'h0, rx_buf};
                IDX_ERRSTAT: next_hrdata = {24'h0, err_stat};
                IDX_IRQSTAT: next_hrdata = {30'h0, irq_stat};
                IDX_IRQMASK: next_hrdata = {30'h0, irq_mask};
                default: next_hrdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mode <= mode_type'(MODE_RESET);
            brgc <= brgc_type'(BRGC_RESET);
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            HRDATA <= 32'h0;
            wr_pend <= 1'b0;
            wr_idx <= 16'h0;
        end else begin
            mode <= next_mode;
            brgc <= next_brgc;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            HRDATA <= next_hrdata;
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
        end
    end

    // ----------------------------------------
    // Bit-rate generator
    // ----------------------------------------
    // Counters restart at each start edge so sampling lands mid-bit.
    logic quad_tick, sel_tick;
    assign quad_tick = pre_cnt == 12'(QUAD_CYC - 1);
    always_comb begin
        case (brgc.clock_select)
            2'h0: sel_tick = quad_tick;
            2'h1: sel_tick = quad_tick && sel_cnt[1:0] == 2'h3;
            2'h2: sel_tick = quad_tick && sel_cnt[2:0] == 3'h7;
            default: sel_tick = quad_tick && sel_cnt == 4'hf;
        endcase
    end
    // k input clocks per half bit, so one bit is 2k input clocks
    assign half_tick = sel_tick && k_cnt == brgc.divide_value - 5'h1;

    always_comb begin
        next_pre_cnt = quad_tick ? 12'h0 : pre_cnt + 12'h1;
        next_sel_cnt = quad_tick ? sel_cnt + 4'h1 : sel_cnt;
        next_k_cnt = half_tick ? 5'h0 : (sel_tick ? k_cnt + 5'h1 : k_cnt);
        if (start_det || !mode.power) begin
            next_pre_cnt = 12'h0;
            next_sel_cnt = 4'h0;
            next_k_cnt = 5'h0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pre_cnt <= 12'h0;
            sel_cnt <= 4'h0;
            k_cnt <= 5'h0;
        end else begin
            pre_cnt <= next_pre_cnt;
            sel_cnt <= next_sel_cnt;
            k_cnt <= next_k_cnt;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    logic sample, par_on;
    assign sample = half_tick && phase;
    assign par_on = mode.parity_mode == PAR_ODD || mode.parity_mode == PAR_EVEN;
    assign start_det = rx_state == RX_IDLE && mode.rx_enable && !RXD;
    // A single stop bit ends the frame whatever the stop length setting
    assign frame_done = rx_state == RX_STOP && sample;
    assign stop_low = !RXD;
    assign ove_now = buf_full && !read_buf;
    // Error mode bit picks which interrupt an erroneous frame raises
    assign ev_err = frame_done && (par_err || stop_low || ove_now)
        && !mode.error_interrupt_mode;
    assign ev_done = frame_done && !ev_err;

    always_comb begin
        next_rx_state = rx_state;
        next_phase = phase;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_par_acc = par_acc;
        next_par_err = par_err;
        next_rx_buf = rx_buf;
        next_buf_full = buf_full && !read_buf;
        next_err_stat = err_stat;
        if (half_tick) next_phase = !phase;
        case (rx_state)
            RX_IDLE: begin
                next_phase = 1'b0;
                if (start_det) next_rx_state = RX_START;
            end
            RX_START: begin
                if (half_tick) begin
                    next_phase = 1'b0;
                    next_bit_cnt = 3'h0;
                    next_shift = 8'h0;
                    next_par_acc = 1'b0;
                    next_par_err = 1'b0;
                    next_rx_state = RXD ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (sample) begin
                    next_shift = {RXD, shift[7:1]};
                    next_par_acc = par_acc ^ RXD;
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (bit_cnt == (mode.char_len8 ? 3'h7 : 3'h6)) begin
                        if (!mode.char_len8) next_shift = {1'b0, RXD, shift[7:2]};
                        next_rx_state = mode.parity_mode != 2'h0 ? RX_PARITY : RX_STOP;
                    end
                end
            end
            RX_PARITY: begin
                if (sample) begin
                    // Even: odd count of ones is an error; odd: even count is
                    next_par_err = par_on && ((par_acc ^ RXD)
                        != (mode.parity_mode == PAR_ODD));
                    next_rx_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (sample) begin
                    next_rx_state = RX_IDLE;
                    next_err_stat = errstat_type'({5'h0, par_err, stop_low, ove_now});
                    if (!ove_now) begin
                        next_rx_buf = shift;
                        next_buf_full = 1'b1;
                    end
                end
            end
            default: next_rx_state = RX_IDLE;
        endcase
        if (!mode.power) begin
            next_rx_state = RX_IDLE;
            next_buf_full = 1'b0;
            next_err_stat = errstat_type'(ERRSTAT_RESET);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rx_state <= RX_IDLE;
            phase <= 1'b0;
            bit_cnt <= 3'h0;
            shift <= 8'h0;
            par_acc <= 1'b0;
            par_err <= 1'b0;
            rx_buf <= 8'h0;
            buf_full <= 1'b0;
            err_stat <= errstat_type'(ERRSTAT_RESET);
        end else begin
            rx_state <= next_rx_state;
            phase <= next_phase;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            par_acc <= next_par_acc;
            par_err <= next_par_err;
            rx_buf <= next_rx_buf;
            buf_full <= next_buf_full;
            err_stat <= next_err_stat;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Cycles since the last half-bit tick, against the length a half bit must have
    logic [19:0] tick_gap, next_tick_gap, half_len;
    logic [4:0] sel_div;
    assign sel_div = brgc.clock_select == 2'h0 ? 5'h1 : 5'(5'h2 << brgc.clock_select);
    assign half_len = 20'(brgc.divide_value) * 20'(sel_div) * 20'(QUAD_CYC);
    always_comb begin
        next_tick_gap = tick_gap + 20'h1;
        if (half_tick || start_det || !mode.power) next_tick_gap = 20'h0;
    end
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            tick_gap <= 20'h0;
        end else begin
            tick_gap <= next_tick_gap;
        end
    end
    AST_STATUS_RESET: assert property (@(posedge REF_CLK)
        !RST_N |=> err_stat == ERRSTAT_RESET)
        else $error("error status not zero after reset");
    AST_STATUS_HIGH_ZERO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        err_stat[7:3] == 5'h0)
        else $error("error status high bits not zero");
    AST_BRGC_RESET: assert property (@(posedge REF_CLK)
        !RST_N |=> brgc == BRGC_RESET)
        else $error("bit-rate control reset value wrong");
    AST_BRGC_BIT5: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !brgc[BRGC_ZERO_BIT])
        else $error("bit-rate control bit 5 set");
    AST_FRAMING: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        frame_done && mode.power |=> err_stat.framing_error_flag == !$past(RXD))
        else $error("framing flag does not follow stop bit");
    AST_OVERRUN_FLAG: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        frame_done && buf_full && !read_buf && mode.power
        |=> err_stat.overrun_error_flag)
        else $error("overrun not flagged");
    AST_OVERRUN_KEEP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        frame_done && ove_now && mode.power |=> $stable(rx_buf) && buf_full)
        else $error("overrun overwrote receive buffer");
    AST_POWER_OFF: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !mode.power |=> rx_state == RX_IDLE && !buf_full)
        else $error("receiver active while disabled");
    AST_ERR_MODE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        frame_done && (par_err || stop_low || ove_now) && mode.power
        |=> (mode.error_interrupt_mode ? irq_stat[IRQ_DONE_BIT] : irq_stat[IRQ_ERR_BIT]))
        else $error("error interrupt steering wrong");
    AST_HALF_BIT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        half_tick && mode.power && brgc.divide_value >= 5'h8 |-> tick_gap == half_len - 20'h1)
        else $error("half bit not k input clocks");
endmodule

/* File: tb/uart_line_model.sv */
// Far-side serial transmitter that drives the receive line of the block.
// Assumes the caller passes the bit time in REF_CLK cycles, as the block is set to.
module uart_line_model
    import uart_rx_pkg::*;
(
    // Clock
    input wire logic REF_CLK,
    // Serial line
    output logic RXD
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Frame sender
    // ----------------------------------------
    // Line idles high between frames, as an async line does
    initial RXD = 1'b1;

    // Start, nd data bits LSB first, a parity bit unless pm is none, one stop bit
    task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic flip,
                        input logic bad_stop, input int bc, input int nd = 8);
        logic [7:0] dm;
        logic p;
        dm = (nd == 7) ? (d & 8'h7f) : d;
        p = (pm == PAR_EVEN) ? ^dm : ~^dm;
        // Zero parity sends a low parity bit whatever the data
        if (pm == 2'h1) p = 1'b0;
        @(posedge REF_CLK);
        RXD <= 1'b0;
        repeat (bc) @(posedge REF_CLK);
        for (int i = 0; i < nd; i++) begin
            RXD <= dm[i];
            repeat (bc) @(posedge REF_CLK);
        end
        if (pm != 2'h0) begin
            RXD <= p ^ flip;
            repeat (bc) @(posedge REF_CLK);
        end
        // A low stop bit and a flipped parity bit are the deliberate faults this model can make
        RXD <= ~bad_stop;
        repeat (bc) @(posedge REF_CLK);
        // One stop bit only, even when two are set in the mode register
        RXD <= 1'b1;
    endtask
endmodule

/* File: tb/uart_rx_status_tb_top.sv */
// Self-checking bench for the receive status and bit-rate block.
// Assumes one AHB-Lite master here and the line model on RXD.
module uart_rx_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_rx_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int QC = 2;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic rxd;
    logic irq;
    logic [31:0] exp_q[$];
    event rd_ev;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [7:0] b;
    logic [7:0] b0;
    int seed_val;

    always #5 ref_clk = ~ref_clk;

    uart_rx_status #(.QUAD_CYC(QC)) dut_u (
        .REF_CLK(ref_clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout), .HWDATA(hwdata),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RXD(rxd), .IRQ(irq));

    uart_line_model line_u (.REF_CLK(ref_clk), .RXD(rxd));
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_tests++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h wanted %h", $time, seen, expd);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Holds each phase until hready is seen high; the watchdog ends a hang
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge ref_clk);
        htrans <= HTRANS_NONSEQ;
        haddr <= {14'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        if (!wr) -> rd_ev;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, {24'h0, d});
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(idx, 1'b0, 32'h0);
    endtask

    // Read data stand from the address-phase edge, so they are settled here
    always @(rd_ev) check(hrdata, exp_q.pop_front());

    task automatic irq_is(input logic e);
        #1 check({31'h0, irq}, {31'h0, e});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed_val = $urandom(78);
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(IDX_BRGC, 8'h1f);
        rd(IDX_ERRSTAT, 8'h00);
        rd(16'h0100, 8'h00);
        wr(IDX_BRGC, 8'hff);
        rd(IDX_BRGC, 8'hdf);
        // Power is off after reset, so the rate may be changed now
        wr(IDX_BRGC, 8'h08);
        wr(IDX_IRQMASK, 8'h03);
        wr(IDX_MODE, 8'hbc);
        b = 8'($urandom);
        line_u.send(b, PAR_EVEN, 1'b0, 1'b0, 32);
        rd(IDX_ERRSTAT, 8'h00);
        rd(IDX_IRQSTAT, 8'h01);
        irq_is(1'b1);
        rd(IDX_RXBUF, b);
        wr(IDX_IRQSTAT, 8'h03);
        rd(IDX_IRQSTAT, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_MODE, {3'b101, i[1] ? PAR_ODD : PAR_EVEN, 3'b100});
            b = 8'($urandom);
            line_u.send(b, i[1] ? PAR_ODD : PAR_EVEN, i[0], 1'b0, 32);
            rd(IDX_ERRSTAT, i[0] ? 8'h04 : 8'h00);
            rd(IDX_RXBUF, b);
            rd(IDX_IRQSTAT, i[0] ? 8'h02 : 8'h01);
            wr(IDX_IRQSTAT, 8'h03);
        end
        // Seven-bit frame with zero parity, then eight bits with no parity
        for (int i = 0; i < 2; i++) begin
            wr(IDX_MODE, i[0] ? 8'ha4 : 8'ha8);
            b = 8'($urandom);
            line_u.send(b, i[0] ? 2'h0 : 2'h1, 1'b1, 1'b0, 32, i[0] ? 8 : 7);
            rd(IDX_ERRSTAT, 8'h00);
            rd(IDX_RXBUF, i[0] ? b : {1'b0, b[6:0]});
            wr(IDX_IRQSTAT, 8'h03);
        end
        // Error with the mode bit set raises only the completion bit
        wr(IDX_MODE, 8'hbd);
        b = 8'($urandom);
        line_u.send(b, PAR_EVEN, 1'b0, 1'b1, 32);
        rd(IDX_ERRSTAT, 8'h02);
        rd(IDX_IRQSTAT, 8'h01);
        rd(IDX_RXBUF, b);
        wr(IDX_IRQSTAT, 8'h03);
        // Three frames back to back with two stop bits selected, none read
        wr(IDX_MODE, 8'hbe);
        b0 = 8'($urandom);
        line_u.send(b0, PAR_EVEN, 1'b0, 1'b0, 32);
        for (int i = 0; i < 2; i++) line_u.send(8'($urandom), PAR_EVEN, 1'b0, 1'b0, 32);
        rd(IDX_ERRSTAT, 8'h01);
        rd(IDX_IRQSTAT, 8'h03);
        rd(IDX_RXBUF, b0);
        b = 8'($urandom);
        line_u.send(b, PAR_EVEN, 1'b0, 1'b0, 32);
        rd(IDX_ERRSTAT, 8'h00);
        rd(IDX_RXBUF, b);
        wr(IDX_IRQSTAT, 8'h03);
        line_u.send(8'($urandom), PAR_EVEN, 1'b0, 1'b1, 32);
        wr(IDX_IRQMASK, 8'h00);
        irq_is(1'b0);
        wr(IDX_IRQMASK, 8'h02);
        irq_is(1'b1);
        wr(IDX_IRQSTAT, 8'h03);
        irq_is(1'b0);
        wr(IDX_MODE, 8'h3e);
        rd(IDX_ERRSTAT, 8'h00);
        // Each clock select at its own rate; rate only rewritten with power off
        for (int s = 0; s < 4; s++) begin
            wr(IDX_MODE, 8'h3c);
            wr(IDX_BRGC, {s[1:0], 1'b0, 5'(8 + s)});
            wr(IDX_MODE, 8'hbc);
            b = 8'($urandom);
            line_u.send(b, PAR_EVEN, 1'b0, 1'b0, 2 * (8 + s) * (s == 0 ? 1 : 2 << s) * QC);
            rd(IDX_RXBUF, b);
            rd(IDX_ERRSTAT, 8'h00);
        end
        // Framing error at the slowest rate, then a system reset in mid-run
        line_u.send(8'($urandom), PAR_EVEN, 1'b0, 1'b1, 2 * 11 * 16 * QC);
        rd(IDX_ERRSTAT, 8'h02);
        irq_is(1'b1);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(IDX_ERRSTAT, 8'h00);
        rd(IDX_BRGC, 8'h1f);
        rd(IDX_IRQSTAT, 8'h00);
        irq_is(1'b0);
        complete_run();
    end

    initial begin
        #600000;
        n_mismatch++;
        complete_run();
    end
endmodule
